/* File: design/eacr_top.sv */
`default_nettype none

module eacr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq,
  // Arithmetic datapath
  output logic calc_start,
  input wire logic calc_done,
  input wire logic calc_point_bad,
  input wire logic dp_we,
  input wire logic [7:0] dp_addr,
  input wire logic [31:0] dp_wdata,
  output logic [31:0] dp_rdata
);

  // ***************************************************
  // Address decode
  // ***************************************************
  function automatic eacr_pkg::eacr_region_t decode(
    input logic [10:0] a
  );
    eacr_pkg::eacr_region_t r;
    r = eacr_pkg::RG_NONE;
    if (a >= eacr_pkg::RAM_BASE) begin
      r = eacr_pkg::RG_RAM;
    end else if (a == eacr_pkg::OFS_CMD) begin
      r = eacr_pkg::RG_CMD;
    end else if (a == eacr_pkg::OFS_FLAGS) begin
      r = eacr_pkg::RG_FLAGS;
    end else if (a == eacr_pkg::OFS_EN) begin
      r = eacr_pkg::RG_EN;
    end
    return r;
  endfunction

  logic [10:0] a_offs;
  logic accept;
  logic narrow;
  logic word_acc;
  eacr_pkg::eacr_region_t a_region;

  logic dph_valid_ff;
  logic dph_write_ff;
  logic dph_ram_ok_ff;
  logic [7:0] dph_idx_ff;
  eacr_pkg::eacr_region_t dph_region_ff;
  logic err1_ff;
  logic err2_ff;

  logic srst_ff;
  logic [3:0] flags_ff;
  logic [3:0] en_ff;
  logic ready_q_ff;
  logic [31:0] ram_ff [eacr_pkg::RAM_WORDS];

  logic ready;
  logic report;
  logic point_bad;
  logic launch;
  logic wr_cmd;
  logic wr_flags;
  logic wr_en;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  assign a_offs = haddr[10:0];
  assign a_region = decode(a_offs);
  assign accept = hsel && hready && htrans[1];
  // Only word transfers reach the registers and RAM
  assign narrow = (hsize != eacr_pkg::SIZE_WORD);
  assign word_acc = accept && !narrow;

  // ***************************************************
  // Bus data phase tracking
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dph_valid_ff <= 1'b0;
      dph_write_ff <= 1'b0;
      dph_ram_ok_ff <= 1'b0;
      dph_idx_ff <= 8'h00;
      dph_region_ff <= eacr_pkg::RG_NONE;
    end else if (hready) begin
      dph_valid_ff <= word_acc;
      dph_write_ff <= hwrite;
      // RAM is cut off from the bus unless the engine is idle and soft reset is clear
      dph_ram_ok_ff <= ready && !srst_ff;
      dph_idx_ff <= a_offs[9:2];
      dph_region_ff <= a_region;
    end
  end

  // Two-cycle error answer for narrow transfers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      err1_ff <= 1'b0;
      err2_ff <= 1'b0;
    end else begin
      err1_ff <= accept && narrow;
      err2_ff <= err1_ff;
    end
  end

  assign hreadyout = !err1_ff;
  assign hresp = err1_ff || err2_ff;

  assign wr_cmd = dph_valid_ff && dph_write_ff &&
                  (dph_region_ff == eacr_pkg::RG_CMD);
  assign wr_flags = dph_valid_ff && dph_write_ff &&
                    (dph_region_ff == eacr_pkg::RG_FLAGS);
  assign wr_en = dph_valid_ff && dph_write_ff &&
                 (dph_region_ff == eacr_pkg::RG_EN);

  // ***************************************************
  // Command register
  // ***************************************************
  // Level held until software writes it back to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      srst_ff <= eacr_pkg::CMD_RST[eacr_pkg::BIT_SRST];
    end else if (wr_cmd) begin
      srst_ff <= hwdata[eacr_pkg::BIT_SRST];
    end
  end

  // Launch is a write of one; zero or a launch while busy does nothing
  assign launch = wr_cmd && hwdata[eacr_pkg::BIT_GO] && !srst_ff;

  eacr_seq u_seq (
    .clk(clk),
    .rstn(rstn),
    .soft_rst(srst_ff),
    .launch(launch),
    .ready(ready),
    .busy_report(report),
    .point_bad(point_bad),
    .calc_start(calc_start),
    .calc_done(calc_done),
    .calc_point_bad(calc_point_bad)
  );

  // ***************************************************
  // Event flags and enables
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ready_q_ff <= 1'b1;
    end else begin
      ready_q_ff <= ready;
    end
  end

  always_comb begin
    flag_set = 4'h0;
    flag_set[eacr_pkg::FLAG_DONE] = ready && !ready_q_ff;
    flag_set[eacr_pkg::FLAG_RAM] = word_acc &&
      (a_region == eacr_pkg::RG_RAM) && !(ready && !srst_ff);
    flag_set[eacr_pkg::FLAG_ADDR] = word_acc &&
      (a_region == eacr_pkg::RG_NONE);
  end

  assign flag_clr = wr_flags ? hwdata[3:0] : 4'h0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (!rstn || srst_ff) begin
      flags_ff <= eacr_pkg::FLAGS_RST;
    end else begin
      flags_ff <= ((flags_ff & ~flag_clr) | flag_set) &
                  eacr_pkg::FLAG_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || srst_ff) begin
      en_ff <= eacr_pkg::EN_RST;
    end else if (wr_en) begin
      en_ff <= hwdata[3:0] & eacr_pkg::FLAG_MASK;
    end
  end

  assign irq = |(flags_ff & en_ff);

  // ***************************************************
  // Accelerator RAM
  // ***************************************************
  // Error word has priority, then the datapath, then the bus
  always_ff @(posedge clk) begin
    if (report) begin
      ram_ff[eacr_pkg::ERR_WORD_IDX] <= point_bad ?
        eacr_pkg::ERR_POINT_BAD : eacr_pkg::ERR_NONE;
    end else if (!ready && dp_we) begin
      ram_ff[dp_addr] <= dp_wdata;
    end else if (dph_valid_ff && dph_write_ff && dph_ram_ok_ff &&
                 dph_region_ff == eacr_pkg::RG_RAM) begin
      ram_ff[dph_idx_ff] <= hwdata;
    end
  end

  assign dp_rdata = ram_ff[dp_addr];

  // ***************************************************
  // Read data
  // ***************************************************
  // Mux of flops in the data phase, so a read right after a write
  // to the same word already sees the new value
  always_comb begin
    hrdata = 32'h00000000;
    if (dph_valid_ff && !dph_write_ff) begin
      unique case (dph_region_ff)
        eacr_pkg::RG_CMD: begin
          hrdata[eacr_pkg::BIT_READY] = ready;
        end
        eacr_pkg::RG_FLAGS: begin
          hrdata[3:0] = flags_ff;
        end
        eacr_pkg::RG_EN: begin
          hrdata[3:0] = en_ff;
        end
        eacr_pkg::RG_RAM: begin
          if (dph_ram_ok_ff) begin
            hrdata = ram_ff[dph_idx_ff];
          end
        end
        eacr_pkg::RG_NONE: begin
          hrdata = 32'h00000000;
        end
        default: begin
          hrdata = 32'h00000000;
        end
      endcase
    end
  end

endmodule // eacr_top

`default_nettype wire

/* File: pkg/eacr_pkg.sv */
`default_nettype none

package eacr_pkg;

  // ***************************************************
  // Address map, offsets within the slave window
  // ***************************************************
  localparam int ADDR_W = 11;
  localparam logic [10:0] OFS_CMD = 11'h000;
  localparam logic [10:0] OFS_FLAGS = 11'h004;
  localparam logic [10:0] OFS_EN = 11'h008;
  localparam logic [10:0] RAM_BASE = 11'h400;
  localparam int RAM_WORDS = 256;
  localparam int RAM_IDX_W = 8;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int BIT_GO = 0;
  localparam int BIT_READY = 1;
  localparam int BIT_SRST = 7;
  localparam int FLAG_DONE = 0;
  localparam int FLAG_RAM = 2;
  localparam int FLAG_ADDR = 3;
  localparam logic [3:0] FLAG_MASK = 4'hd;
  localparam logic [31:0] CMD_RST = 32'h00000002;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] EN_RST = 4'h0;

  // ***************************************************
  // Error word left in RAM after a computation
  // ***************************************************
  localparam logic [7:0] ERR_WORD_IDX = 8'h00;
  localparam logic [31:0] ERR_POINT_BAD = 32'h00000001;
  localparam logic [31:0] ERR_NONE = 32'h00000000;

  // ***************************************************
  // Bus encodings, region and state types
  // ***************************************************
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    RG_CMD,
    RG_FLAGS,
    RG_EN,
    RG_RAM,
    RG_NONE
  } eacr_region_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_REPORT
  } eacr_state_t;

endpackage

`default_nettype wire

/* File: design/eacr_seq.sv */
`default_nettype none

module eacr_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_rst,
  // Control
  input wire logic launch,
  output logic ready,
  output logic busy_report,
  output logic point_bad,
  // Datapath handshake
  output logic calc_start,
  input wire logic calc_done,
  input wire logic calc_point_bad
);

  eacr_pkg::eacr_state_t state_ff;
  eacr_pkg::eacr_state_t nxt_state;
  logic bad_ff;

  // ***************************************************
  // Sequencer
  // ***************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      eacr_pkg::ST_IDLE: begin
        if (launch) begin
          nxt_state = eacr_pkg::ST_RUN;
        end
      end
      eacr_pkg::ST_RUN: begin
        if (calc_done) begin
          nxt_state = eacr_pkg::ST_REPORT;
        end
      end
      eacr_pkg::ST_REPORT: begin
        nxt_state = eacr_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = eacr_pkg::ST_IDLE;
      end
    endcase
  end

  // Soft reset drops any computation in flight
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      state_ff <= eacr_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      bad_ff <= 1'b0;
    end else if (state_ff == eacr_pkg::ST_RUN && calc_done) begin
      bad_ff <= calc_point_bad;
    end
  end

  assign ready = (state_ff == eacr_pkg::ST_IDLE);
  assign busy_report = (state_ff == eacr_pkg::ST_REPORT);
  assign point_bad = bad_ff;
  assign calc_start = (state_ff == eacr_pkg::ST_IDLE) && launch;

endmodule // eacr_seq

`default_nettype wire

/* File: verification/eacr_dp_model.sv */
`default_nettype none

module eacr_dp_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Engine handshake
  input wire logic start,
  input wire logic bad,
  input wire logic [31:0] data,
  input wire logic [7:0] lat,
  output logic done,
  output logic pbad,
  // Engine RAM port
  output logic we,
  output logic [7:0] addr,
  output logic [31:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;

  // Idle pbad, addr and wdata lines toggle so a stale value never looks valid; done and we stay low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
      done <= 1'b0;
      pbad <= 1'b0;
      we <= 1'b0;
      addr <= 8'h00;
      wdata <= 32'h0;
    end else begin
      done <= (cnt_ff == 8'h01);
      pbad <= (cnt_ff == 8'h01) ? bad : ~pbad;
      we <= start;
      addr <= start ? 8'h01 : ~addr;
      wdata <= start ? data : ~wdata;
      if (start) begin
        cnt_ff <= lat;
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule // eacr_dp_model

`default_nettype wire

/* File: verification/eacr_top_checker.sv */
`default_nettype none

module eacr_top_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Engine
  input wire logic calc_start,
  input wire logic calc_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk, cmdw, rd_ff, rb_ff, busy_ff;
  logic [10:0] a_ff;
  assign tk = hsel & hready & htrans[1];
  assign cmdw = tk & hwrite & (haddr[10:0] == eacr_pkg::OFS_CMD);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_ff <= 1'b0;
      rb_ff <= 1'b0;
      a_ff <= 11'h000;
    end else begin
      rd_ff <= tk & !hwrite & (hsize == eacr_pkg::SIZE_WORD);
      rb_ff <= tk & !hwrite & haddr[10] & busy_ff;
      a_ff <= haddr[10:0];
    end
  end

  // Busy from the launch until the engine reports back
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else if (calc_start) begin
      busy_ff <= 1'b1;
    end else if (calc_done) begin
      busy_ff <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_err;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence

  chk_narrow_err: assert property (
    tk && hsize != eacr_pkg::SIZE_WORD |=> s_err)
    else $error("narrow transfer not refused");
  chk_word_okay: assert property (
    tk && hsize == eacr_pkg::SIZE_WORD |=> hreadyout && !hresp)
    else $error("word transfer not answered okay");
  chk_start_cause: assert property (
    calc_start |-> $past(cmdw) && hwdata[0])
    else $error("launch without command write");
  chk_start_pulse: assert property (
    calc_start |=> !calc_start [*2])
    else $error("launch pulse too long");
  chk_no_relaunch: assert property (
    calc_start |-> !busy_ff)
    else $error("launch taken while busy");
  chk_cmd_read: assert property (
    rd_ff && a_ff == eacr_pkg::OFS_CMD |-> hrdata[31:2] == 30'h0
      && !hrdata[0] && !(busy_ff && hrdata[1]))
    else $error("command word read wrong");
  chk_flags_rsvd: assert property (
    rd_ff && (a_ff == eacr_pkg::OFS_FLAGS || a_ff == eacr_pkg::OFS_EN)
      |-> hrdata[31:4] == 28'h0 && !hrdata[1])
    else $error("reserved bits not zero");
  chk_ram_busy: assert property (
    rb_ff |-> hrdata == 32'h0)
    else $error("RAM readable while busy");
endmodule // eacr_top_checker

bind eacr_top eacr_top_checker eacr_top_checker_i (.clk(clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .calc_start(calc_start),
  .calc_done(calc_done));

`default_nettype wire

/* File: verification/eacr_tb_top.sv */
`default_nettype none

module eacr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, bad = 0;
  logic dn, pb, we, cs, hro, hresp, irq, eb;
  wire logic hready;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] lat = 8'h01, da;
  logic [31:0] haddr = 0, hwdata = 0, dat = 0, hrd, dwd, drd, r;
  logic [31:0] rs = 32'heac7;
  int fails = 0, num_checks = 0, cyc = 0, mf = 0, me = 0, k;
  assign hready = hro;
  always #25 clk = ~clk;

  eacr_top eacr_top_i (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hro), .hresp(hresp), .hrdata(hrd),
    .irq(irq), .calc_start(cs), .calc_done(dn), .calc_point_bad(pb),
    .dp_we(we), .dp_addr(da), .dp_wdata(dwd), .dp_rdata(drd));
  eacr_dp_model eacr_dp_model_i (.clk(clk), .rstn(rstn), .start(cs),
    .bad(bad), .data(dat), .lat(lat), .done(dn), .pbad(pb), .we(we),
    .addr(da), .wdata(dwd));

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [2:0] sz);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hro !== 1'b1);
    r = hrd;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0, 3'h2);
    chk(r, e);
    if (a == 32'h4) chk(irq, |(mf & me));
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(32'h0, 32'h2);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    me = 'hd;
    xf(1'b1, 32'h8, 32'hffffffff, 3'h2);
    rd(32'h8, me);
    rd(32'h00c, 32'h0);
    mf = 8;
    rd(32'h4, mf);
    xf(1'b1, 32'h4, 32'h7, 3'h2);
    rd(32'h4, mf);
    xf(1'b1, 32'h4, 32'h8, 3'h2);
    mf = 0;
    rd(32'h4, 32'h0);
    xf(1'b1, 32'h8, 32'h0, 3'h0);
    chk(hresp, 1'b1);
    rd(32'h8, me);
    for (int i = 0; i < 3; i++) begin
      rs = lfsr(rs);
      eb = rs[0];
      lat <= (i == 0) ? 8'h01 : 8'h28;
      bad <= eb;
      dat <= rs;
      xf(1'b1, 32'h0, 32'h1, 3'h2);
      if (i > 0) begin
        rd(32'h0, 32'h0);
        // Dropped while busy; the word read back later proves it
        xf(1'b1, 32'h404, 32'h0, 3'h2);
        rd(32'h400, 32'h0);
        mf = 4;
        rd(32'h4, mf);
      end
      xf(1'b1, 32'h0, 32'h0, 3'h2);
      k = 0;
      do begin
        xf(1'b0, 32'h0, 32'h0, 3'h2);
        k++;
      end while (r !== 32'h2 && k < 100);
      chk(r, 32'h2);
      mf = mf | 1;
      rd(32'h4, mf);
      rd(32'h400, {31'h0, eb});
      rd(32'h404, rs);
      // Engine side read port alternates between words 1 and 0xfe
      if (da !== 8'h01) @(posedge clk);
      chk(drd, rs);
      xf(1'b1, 32'h4, mf, 3'h2);
      mf = 0;
      rd(32'h4, 32'h0);
    end
    xf(1'b1, 32'h0, 32'h80, 3'h2);
    me = 0;
    rd(32'h8, 32'h0);
    xf(1'b1, 32'h0, 32'h81, 3'h2);
    rd(32'h404, 32'h0);
    xf(1'b1, 32'h0, 32'h0, 3'h2);
    rd(32'h0, 32'h2);
    // Flag set with its enable clear must keep the interrupt low
    rd(32'h00c, 32'h0);
    mf = 8;
    rd(32'h4, mf);
    finish_test();
  end
endmodule // eacr_tb_top

`default_nettype wire
